// [wcd_regs.svh]
// Encodings, field positions and data constants for the watchdog-clear and decrement decoder.
// Assumes a 14-bit instruction word and 8-bit file registers.
`ifndef WCD_REGS_SVH
`define WCD_REGS_SVH
`define WCD_INSTR_W 14
`define WCD_DATA_W 8
`define WCD_ADDR_W 7
`define WCD_WATCHDOG_CLEAR_WORD 14'h0064
`define WCD_OPC_HI 13
`define WCD_OPC_LO 8
`define WCD_OPC_DECREMENT 6'h03
`define WCD_OPC_DECREMENT_SKIP 6'h0b
`define WCD_DEST_BIT 7
`define WCD_ADDR_HI 6
`define WCD_ADDR_LO 0
`define WCD_DATA_ONE 8'h01
`define WCD_DATA_ZERO 8'h00
`endif

// [wcd_pkg.sv]
// Types for the decoder's state register; the decrement unit does not use them.
// Assumes wcd_regs.svh is on the include path.
`include "wcd_regs.svh"
package wcd_pkg;
  typedef enum logic [1:0] {
    WCD_EXEC = 2'h1,
    WCD_SKIP = 2'h2
  } wcd_state_t;

  typedef struct packed {
    wcd_state_t phase;
    logic [`WCD_DATA_W-1:0] result;
    logic writeW;
    logic writeFile;
    logic [`WCD_ADDR_W-1:0] fileAddr;
    logic zeroWrite;
    logic zeroValue;
    logic watchdogClear;
    logic flagsSet;
    logic discard;
  } wcd_state_reg_t;
endpackage : wcd_pkg

// [wcd_dec_if.sv]
// Interface carrying the operand to the decrement unit and its answer back.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
`include "wcd_regs.svh"
interface wcd_dec_if;
  logic [`WCD_DATA_W-1:0] operand;
  logic [`WCD_DATA_W-1:0] difference;
  logic isZero;
  modport core (output operand, input difference, input isZero);
  modport unit (input operand, output difference, output isZero);
endinterface : wcd_dec_if

// [wcd_decrement.sv]
// Single-cycle combinational decrement with a zero detect.
// Assumes the operand is stable for the cycle in which it is read.
`timescale 1ns/1ps
`include "wcd_regs.svh"
module wcd_decrement (
  wcd_dec_if.unit dec
);
  assign dec.difference = dec.operand - `WCD_DATA_ONE;
  assign dec.isZero = (dec.difference == `WCD_DATA_ZERO);
endmodule : wcd_decrement

// [wcd_core.sv]
// Decode and execute for watchdog clear, decrement and decrement-with-skip.
// Assumes fileData is the value of the register at the instruction's address, read in the same cycle.
`timescale 1ns/1ps
`include "wcd_regs.svh"
module wcd_core
  import wcd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [`WCD_INSTR_W-1:0] instrWord,
  input wire logic [`WCD_DATA_W-1:0] fileData,
  output logic [`WCD_ADDR_W-1:0] fileAddr,
  output logic [`WCD_DATA_W-1:0] resultData,
  output logic workingWriteEn,
  output logic fileWriteEn,
  output logic [`WCD_ADDR_W-1:0] fileWriteAddr,
  output logic zeroFlagWriteEn,
  output logic zeroFlagValue,
  output logic watchdogClear,
  output logic timeoutFlagSet,
  output logic powerdownFlagSet,
  output logic discardFetched,
  output logic busy
);
  wcd_state_reg_t st;
  wcd_state_reg_t next_st;
  wcd_dec_if dec ();

  wcd_decrement u_dec (
    .dec(dec.unit)
  );

  logic [5:0] opcode;
  logic isClear;
  logic isDec;
  logic isDecSkip;
  logic destFile;

  assign opcode = instrWord[`WCD_OPC_HI:`WCD_OPC_LO];
  assign isClear = instrWord == `WCD_WATCHDOG_CLEAR_WORD;
  assign isDec = opcode == `WCD_OPC_DECREMENT;
  assign isDecSkip = opcode == `WCD_OPC_DECREMENT_SKIP;
  assign destFile = instrWord[`WCD_DEST_BIT];
  assign fileAddr = instrWord[`WCD_ADDR_HI:`WCD_ADDR_LO];
  assign dec.operand = fileData;

  always_comb begin
    next_st = st;
    next_st.writeW = 1'b0;
    next_st.writeFile = 1'b0;
    next_st.zeroWrite = 1'b0;
    next_st.watchdogClear = 1'b0;
    next_st.flagsSet = 1'b0;
    next_st.discard = 1'b0;
    case (st.phase)
      WCD_EXEC: begin
        if (instrValid) begin
          if (isClear) begin
            next_st.watchdogClear = 1'b1;
            next_st.flagsSet = 1'b1;
          end else if (isDec || isDecSkip) begin
            next_st.result = dec.difference;
            next_st.fileAddr = fileAddr;
            next_st.writeW = !destFile;
            next_st.writeFile = destFile;
            next_st.zeroWrite = isDec;
            next_st.zeroValue = dec.isZero;
            if (isDecSkip && dec.isZero) begin
              next_st.discard = 1'b1;
              next_st.phase = WCD_SKIP;
            end
          end
        end
      end
      // The discarded word is ignored here; fetch still presents it, so decoding it would execute the skipped instruction.
      WCD_SKIP: begin
        next_st.phase = WCD_EXEC;
      end
      default: begin
        next_st.phase = WCD_EXEC;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '{phase: WCD_EXEC, result: '0, writeW: 1'b0, writeFile: 1'b0, fileAddr: '0,
              zeroWrite: 1'b0, zeroValue: 1'b0, watchdogClear: 1'b0, flagsSet: 1'b0, discard: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign resultData = st.result;
  assign workingWriteEn = st.writeW;
  assign fileWriteEn = st.writeFile;
  assign fileWriteAddr = st.fileAddr;
  assign zeroFlagWriteEn = st.zeroWrite;
  assign zeroFlagValue = st.zeroValue;
  assign watchdogClear = st.watchdogClear;
  assign timeoutFlagSet = st.flagsSet;
  assign powerdownFlagSet = st.flagsSet;
  assign discardFetched = st.discard;
  assign busy = st.phase == WCD_SKIP;
endmodule : wcd_core

// [wcd_monitor.sv]
// Checker on the ports of wcd_core.
// Assumes a bind from the bench top.
`timescale 1ns/1ps
module wcd_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [13:0] instrWord,
  input wire logic [7:0] fileData,
  input wire logic [7:0] resultData,
  input wire logic workingWriteEn,
  input wire logic fileWriteEn,
  input wire logic zeroFlagWriteEn,
  input wire logic zeroFlagValue,
  input wire logic watchdogClear,
  input wire logic discardFetched,
  input wire logic busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic go = instrValid && !busy;
  wire logic dec = go && instrWord[13:8] == 6'h03;
  wire logic skp = go && instrWord[13:8] == 6'h0b;
  sequence skipping; discardFetched && busy ##1 !busy; endsequence
  chk_clear_set: assert property (go && instrWord == 14'h0064 |=> watchdogClear) else $error("clear");
  chk_minus_one: assert property (dec |=> resultData == $past(fileData) - 8'h01) else $error("value");
  chk_dest_bit: assert property (dec |=> fileWriteEn == $past(instrWord[7]) && workingWriteEn != fileWriteEn)
    else $error("route");
  chk_skip_flag: assert property (skp |=> !zeroFlagWriteEn && resultData == $past(fileData) - 8'h01)
    else $error("skip");
  chk_skip_zero: assert property (skp && fileData == 8'h01 |=> skipping) else $error("discard");
  chk_skip_len: assert property (skp && fileData != 8'h01 |=> !busy) else $error("busy");
  chk_zero_flag: assert property (dec |=> zeroFlagWriteEn && zeroFlagValue == (resultData == 8'h00))
    else $error("zero");
endmodule : wcd_monitor

// [wdt_clear_and_decrement_ops_test.sv]
// Bench for wcd_core, directed then random.
// Needs the design files and wcd_monitor.sv first.
`timescale 1ns/1ps
module wdt_clear_and_decrement_ops_test;
  logic sys_clk = 1'b0, rst = 1'b1, instrValid = 1'b0, pend = 1'b0, dc, sk, cl;
  logic workingWriteEn, fileWriteEn, zeroFlagWriteEn, zeroFlagValue, watchdogClear;
  logic timeoutFlagSet, powerdownFlagSet, discardFetched, busy;
  logic [13:0] instrWord = 14'h0000;
  logic [7:0] fileData = 8'h00, resultData;
  logic [6:0] fileAddr, fileWriteAddr;
  logic [31:0] seed = 32'h912c;
  int n_errors = 0, check_count = 0, cyc = 0;
  wcd_core dut_u (.*);
  initial forever #4 sys_clk = ~sys_clk;
  task automatic chk(input logic ok);
    check_count++;
    if (!ok) begin
      n_errors++;
      $display("wrong value at %0t: port", $time);
    end
  endtask : chk
  // Words are sent back to back, so the word after a skip lands in the busy cycle.
  task automatic run(input logic [13:0] w, input logic [7:0] d);
    dc = !pend && w[13:8] == 6'h03;
    sk = !pend && w[13:8] == 6'h0b;
    cl = !pend && w == 14'h0064;
    instrValid <= 1'b1;
    instrWord <= w;
    fileData <= d;
    @(posedge sys_clk);
    #1;
    chk(watchdogClear === cl && timeoutFlagSet === cl && powerdownFlagSet === cl);
    chk(fileWriteEn === ((dc || sk) && w[7]) && (!(dc || sk) || resultData === d - 8'h01));
    chk(zeroFlagWriteEn === dc && busy === (sk && d == 8'h01));
    chk(workingWriteEn === ((dc || sk) && !w[7]) && discardFetched === (sk && d == 8'h01));
    chk(!dc || zeroFlagValue === (d == 8'h01));
    chk(!(dc || sk) || fileWriteAddr === w[6:0]);
    pend = sk && d == 8'h01;
  endtask : run
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic test_done();
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  always @(posedge sys_clk) begin
    if (++cyc == 600) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    run(14'h0b85, 8'h01);
    run(14'h0305, 8'h22);
    for (int i = 0; i < 400; i++) begin
      seed = xs(seed);
      run(seed[2] ? 14'h0064 : {seed[0] ? 6'h0b : 6'h03, seed[15:8]}, seed[3] ? 8'h01 : seed[31:24]);
    end
    test_done();
  end
endmodule : wdt_clear_and_decrement_ops_test
bind wcd_core wcd_monitor mon_u (.*);
